// ===== rtl/emf_regs.sv
`timescale 1ns/1ns
`default_nettype none
module emf_regs
  import emf_pkg::*;
#(
  parameter bit FEC_PRESENT = 1'b1
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PHY_RST_I,
  input wire emf_req_t MGMT_REQ_I,
  output emf_rsp_t MGMT_RSP_O,
  input wire emf_fec_evt_t FEC_EVT_I,
  output logic FEC_ENABLE_O,
  output logic FEC_ERR_IND_EN_O,
  output logic [EMF_NUM_CNT-1:0] CNT_SAT_O
);

  function automatic logic addr_is(input logic [EMF_AW-1:0] a, input logic [EMF_AW-1:0] off);
    return a == off;
  endfunction

  logic clear_all;
  logic rd_req;
  logic wr_req;
  logic hit_ctrl;
  logic hit_stat;
  logic [EMF_NUM_CNT-1:0] hit_cnt;
  logic [EMF_NUM_CNT-1:0] evt_vec;
  logic [EMF_NUM_CNT-1:0] rd_clr;
  logic [EMF_NUM_CNT-1:0] inc;
  logic [EMF_DW-1:0] cnt_val [EMF_NUM_CNT];
  logic [EMF_DW-1:0] rd_chain [EMF_NUM_CNT+1];
  logic [EMF_DW-1:0] ctrl_reg;
  logic [EMF_DW-1:0] ctrl_next;
  logic [EMF_DW-1:0] stat_val;
  logic [EMF_DW-1:0] rd_ctrl;
  logic [EMF_DW-1:0] rd_stat;
  logic [EMF_DW-1:0] rd_mux;
  logic ack_reg;
  logic [EMF_DW-1:0] rdata_reg;

  // A PHY reset clears the control register and counters like the block reset; ack_reg and rdata_reg see only RST_I.
  assign clear_all = RST_I | PHY_RST_I;
  assign rd_req = MGMT_REQ_I.valid & ~MGMT_REQ_I.write;
  assign wr_req = MGMT_REQ_I.valid & MGMT_REQ_I.write;
  assign hit_ctrl = addr_is(MGMT_REQ_I.addr, EMF_ADDR_CTRL);
  assign hit_stat = addr_is(MGMT_REQ_I.addr, EMF_ADDR_STAT);
  assign evt_vec = FEC_EVT_I;

  // Only the defined control bits are stored, so reserved bits cannot steer anything.
  // Status and counters are read-only and have no write path at all.
  assign ctrl_next = (wr_req && hit_ctrl && FEC_PRESENT) ?
                     (MGMT_REQ_I.wdata & EMF_CTRL_MASK) : ctrl_reg;

  always_ff @(posedge MCLK_I) begin
    if (clear_all) begin
      ctrl_reg <= EMF_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign FEC_ENABLE_O = ctrl_reg[EMF_CTRL_EN_BIT];
  assign FEC_ERR_IND_EN_O = ctrl_reg[EMF_CTRL_IND_BIT];

  // Ability bits report what was built; without FEC every bit is unsupported.
  always_comb begin
    stat_val = EMF_ZERO;
    stat_val[EMF_STAT_ABIL_BIT] = FEC_PRESENT;
    stat_val[EMF_STAT_IND_ABIL_BIT] = FEC_PRESENT;
  end

  assign rd_ctrl = (hit_ctrl && FEC_PRESENT) ? (ctrl_reg & EMF_CTRL_MASK) : EMF_ZERO;
  assign rd_stat = hit_stat ? stat_val : EMF_ZERO;
  assign rd_chain[0] = rd_ctrl | rd_stat;

  genvar gi;
  generate
    for (gi = 0; gi < EMF_NUM_CNT; gi++) begin : g_cnt
      assign hit_cnt[gi] = addr_is(MGMT_REQ_I.addr, EMF_ADDR_CNT_BASE + EMF_AW'(gi));
      // Counters only read back, clear on read and count when FEC is built in.
      assign rd_clr[gi] = rd_req & hit_cnt[gi] & FEC_PRESENT;
      assign inc[gi] = evt_vec[gi] & FEC_PRESENT;
      assign CNT_SAT_O[gi] = (cnt_val[gi] == EMF_CNT_MAX);
      // Pre-clear value is taken here in the same cycle as the clear.
      assign rd_chain[gi+1] = rd_chain[gi] |
                              ((hit_cnt[gi] && FEC_PRESENT) ? cnt_val[gi] : EMF_ZERO);

      emf_sat_counter u_cnt (
        .MCLK_I(MCLK_I),
        .srst_i(clear_all),
        .rd_clr_i(rd_clr[gi]),
        .inc_i(inc[gi]),
        .count_o(cnt_val[gi])
      );
    end
  endgenerate

  // Unmapped addresses fall through as zero, so every address gets an answer.
  assign rd_mux = rd_chain[EMF_NUM_CNT];

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      ack_reg <= 1'b0;
      rdata_reg <= EMF_ZERO;
    end else begin
      ack_reg <= MGMT_REQ_I.valid;
      rdata_reg <= rd_req ? rd_mux : EMF_ZERO;
    end
  end

  assign MGMT_RSP_O.ack = ack_reg;
  assign MGMT_RSP_O.rdata = rdata_reg;

endmodule // emf_regs
`default_nettype wire

// ===== rtl/emf_pkg.sv
// Contract
// - Every address in device space is answered.
// - Writes to undefined or read-only registers ignored.
// - Reserved-bit writes never change operation.
// - Reserved and unsupported bits read zero.
// - FEC register behaviour only when FEC present.
// - FEC control bits cleared on PHY reset.
// - FEC counters clear on read and reset.
// - FEC counters saturate at all ones.
package emf_pkg;

  localparam int unsigned EMF_DW = 16;
  localparam int unsigned EMF_AW = 16;
  localparam int unsigned EMF_NUM_CNT = 3;

  // Register offsets inside the management device space.
  localparam logic [EMF_AW-1:0] EMF_ADDR_CTRL = 16'h0000;
  localparam logic [EMF_AW-1:0] EMF_ADDR_STAT = 16'h0001;
  localparam logic [EMF_AW-1:0] EMF_ADDR_CNT_BASE = 16'h0002;

  // Control register fields.
  localparam int unsigned EMF_CTRL_EN_BIT = 0;
  localparam int unsigned EMF_CTRL_IND_BIT = 1;
  localparam logic [EMF_DW-1:0] EMF_CTRL_MASK = 16'h0003;
  localparam logic [EMF_DW-1:0] EMF_CTRL_RST = 16'h0000;

  // Status register fields.
  localparam int unsigned EMF_STAT_ABIL_BIT = 0;
  localparam int unsigned EMF_STAT_IND_ABIL_BIT = 1;

  // Counter values.
  localparam logic [EMF_DW-1:0] EMF_CNT_RST = 16'h0000;
  localparam logic [EMF_DW-1:0] EMF_CNT_MAX = 16'hffff;
  localparam logic [EMF_DW-1:0] EMF_ZERO = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [EMF_AW-1:0] addr;
    logic [EMF_DW-1:0] wdata;
  } emf_req_t;

  typedef struct packed {
    logic ack;
    logic [EMF_DW-1:0] rdata;
  } emf_rsp_t;

  // Bit 0 feeds counter 0, bit 1 counter 1, bit 2 counter 2.
  typedef struct packed {
    logic symbol_err;
    logic uncorrected;
    logic corrected;
  } emf_fec_evt_t;

endpackage

// ===== rtl/emf_sat_counter.sv
`timescale 1ns/1ns
`default_nettype none
module emf_sat_counter
  import emf_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic srst_i,
  input wire logic rd_clr_i,
  input wire logic inc_i,
  output logic [EMF_DW-1:0] count_o
);

  logic [EMF_DW-1:0] count_reg;
  logic [EMF_DW-1:0] count_next;
  logic [EMF_DW-1:0] base;

  // A read clears first, then a same-cycle event lands on the fresh zero.
  assign base = rd_clr_i ? EMF_CNT_RST : count_reg;
  assign count_next = (inc_i && base != EMF_CNT_MAX) ? base + 16'h0001 : base;
  assign count_o = count_reg;

  always_ff @(posedge MCLK_I) begin
    if (srst_i) begin
      count_reg <= EMF_CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // emf_sat_counter
`default_nettype wire

// ===== bench/emf_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module emf_regs_checker
  import emf_pkg::*;
#(parameter bit FEC_PRESENT = 1'b1) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic PHY_RST_I,
  input wire emf_req_t MGMT_REQ_I,
  input wire emf_rsp_t MGMT_RSP_O,
  input wire emf_fec_evt_t FEC_EVT_I,
  input wire logic FEC_ENABLE_O,
  input wire logic FEC_ERR_IND_EN_O,
  input wire logic [EMF_NUM_CNT-1:0] CNT_SAT_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  wire rdq = MGMT_REQ_I.valid && !MGMT_REQ_I.write;
  wire [15:0] ad = MGMT_REQ_I.addr;
  wire [15:0] rd = MGMT_RSP_O.rdata;
  wire [1:0] wd = MGMT_REQ_I.wdata[1:0];
  wire [1:0] ct = {FEC_ERR_IND_EN_O, FEC_ENABLE_O};
  wire cw = MGMT_REQ_I.valid && MGMT_REQ_I.write && ad == 16'h0000;
  wire r2 = rdq && ad == 16'h0002 && !PHY_RST_I;
  property p_ack; MGMT_REQ_I.valid |=> MGMT_RSP_O.ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_wr; FEC_PRESENT && cw && !PHY_RST_I |=> ct == $past(wd); endproperty
  a_wr: assert property (p_wr) else $error("control write");
  property p_hold; !cw && !PHY_RST_I |=> $stable(ct); endproperty
  a_hold: assert property (p_hold) else $error("control moved");
  property p_phy; PHY_RST_I |=> ct == 2'h0 && CNT_SAT_O == 3'h0; endproperty
  a_phy: assert property (p_phy) else $error("phy reset");
  property p_st; rdq && ad == 16'h0001 |=> rd == {14'h0000, {2{FEC_PRESENT}}}; endproperty
  a_st: assert property (p_st) else $error("status read");
  property p_un; rdq && ad > 16'h0004 |=> rd == 16'h0000; endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_sat; CNT_SAT_O[0] && !r2 && !PHY_RST_I |=> CNT_SAT_O[0]; endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");
  property p_clr; r2 && CNT_SAT_O[0] |=> rd == 16'hffff && !CNT_SAT_O[0]; endproperty
  a_clr: assert property (p_clr) else $error("read clear");
endmodule // emf_regs_checker
bind emf_regs emf_regs_checker #(.FEC_PRESENT(FEC_PRESENT)) u_chk (.MCLK_I(MCLK_I),
  .RST_I(RST_I), .PHY_RST_I(PHY_RST_I), .MGMT_REQ_I(MGMT_REQ_I), .MGMT_RSP_O(MGMT_RSP_O),
  .FEC_EVT_I(FEC_EVT_I), .FEC_ENABLE_O(FEC_ENABLE_O),
  .FEC_ERR_IND_EN_O(FEC_ERR_IND_EN_O), .CNT_SAT_O(CNT_SAT_O));
`default_nettype wire

// ===== bench/emf_sta_model.sv
`timescale 1ns/1ns
`default_nettype none
module emf_sta_model
  import emf_pkg::*;
(
  input wire logic MCLK_I,
  input wire emf_rsp_t rsp_i,
  output emf_req_t req_o
);
  initial req_o = '0;
  // Idle lines show the inverse so stale fields are never mistaken for live ones.
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] r,
                      output logic ok);
    @(negedge MCLK_I);
    req_o = '{1'b1, w, a, d};
    @(negedge MCLK_I);
    req_o = '{1'b0, ~w, ~a, ~d};
    ok = rsp_i.ack;
    r = rsp_i.rdata;
  endtask
endmodule // emf_sta_model
`default_nettype wire

// ===== bench/test_emf_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_emf_regs;
  import emf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, prst = 1'b0, en, ie, ok;
  logic [2:0] sat;
  logic [15:0] r;
  emf_req_t req;
  emf_rsp_t rsp;
  emf_fec_evt_t evt = '0;
  int errors = 0, checks = 0;
  emf_regs dut (.MCLK_I(clk), .RST_I(rst), .PHY_RST_I(prst), .MGMT_REQ_I(req),
    .MGMT_RSP_O(rsp), .FEC_EVT_I(evt), .FEC_ENABLE_O(en), .FEC_ERR_IND_EN_O(ie),
    .CNT_SAT_O(sat));
  emf_sta_model sta (.MCLK_I(clk), .rsp_i(rsp), .req_o(req));
  // A second copy built without FEC shares the event lines, so every event is offered to it.
  logic en0, ie0;
  logic [2:0] sat0;
  emf_req_t req0;
  emf_rsp_t rsp0;
  emf_regs #(.FEC_PRESENT(1'b0)) dut0 (.MCLK_I(clk), .RST_I(rst), .PHY_RST_I(prst),
    .MGMT_REQ_I(req0), .MGMT_RSP_O(rsp0), .FEC_EVT_I(evt), .FEC_ENABLE_O(en0),
    .FEC_ERR_IND_EN_O(ie0), .CNT_SAT_O(sat0));
  emf_sta_model sta0 (.MCLK_I(clk), .rsp_i(rsp0), .req_o(req0));
  initial forever #20 clk = ~clk;
  task chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
    end
  endtask
  task rd(input logic [15:0] a, e);
    sta.xfer(1'b0, a, 16'h0000, r, ok);
    chk(ok, 16'h0001);
    chk(r, e);
  endtask
  task wr(input logic [15:0] a, d);
    sta.xfer(1'b1, a, d, r, ok);
    chk(ok, 16'h0001);
    chk(r, 16'h0000);
  endtask
  task t_nofec;
    sta0.xfer(1'b1, 16'h0000, 16'h0003, r, ok);
    chk(ok, 16'h0001);
    chk({ie0, en0}, 16'h0000);
    sta0.xfer(1'b0, 16'h0000, 16'h0000, r, ok);
    chk(r, 16'h0000);
    sta0.xfer(1'b0, 16'h0001, 16'h0000, r, ok);
    chk(r, 16'h0000);
    sta0.xfer(1'b0, 16'h0002, 16'h0000, r, ok);
    chk(r, 16'h0000);
    chk(sat0, 16'h0000);
  endtask
  task pulse(input int i, n);
    @(negedge clk);
    evt[i] = 1'b1;
    repeat (n) @(negedge clk);
    evt = '0;
  endtask
  task t_regs;
    wr(16'h0000, 16'hfffe);
    chk({ie, en}, 16'h0002);
    rd(16'h0000, 16'h0002);
    wr(16'h0001, 16'h0000);
    rd(16'h0001, 16'h0003);
    wr(16'h0100, 16'hffff);
    rd(16'h0100, 16'h0000);
    chk({ie, en}, 16'h0002);
  endtask
  task t_cnt;
    for (int i = 0; i < 3; i++) begin
      pulse(i, 5);
      rd(16'h0002 + i, 16'h0005);
      rd(16'h0002 + i, 16'h0000);
    end
  endtask
  task t_phy;
    wr(16'h0000, 16'h0003);
    pulse(1, 3);
    prst = 1'b1;
    @(negedge clk);
    prst = 1'b0;
    chk({ie, en}, 16'h0000);
    rd(16'h0003, 16'h0000);
  endtask
  // An event coincident with the clearing read must survive as a count of one.
  task t_sat;
    pulse(0, 65540);
    chk(sat, 16'h0001);
    fork
      sta.xfer(1'b0, 16'h0002, 16'h0000, r, ok);
      pulse(0, 1);
    join
    chk(r, 16'hffff);
    rd(16'h0002, 16'h0001);
  endtask
  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_cnt;
    t_phy;
    t_sat;
    t_nofec;
    results;
  end
endmodule // test_emf_regs
`default_nettype wire
